// >>> core/charger_alert_pkg.sv
package charger_alert_pkg;
	// clock and time base
	localparam int CLK_HZ = 40_000_000;
	localparam int US_PER_S = 1_000_000;
	localparam int CYC_PER_US = CLK_HZ / US_PER_S;
	localparam int CNT_W = 28;
	typedef logic [CNT_W-1:0] cnt_t;

	// bus address, arbitrary value
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h09;

	// command codes
	localparam logic [7:0] CMD_THR = 8'h48;
	localparam int NCFG = 7;
	localparam int CFG_A = 0;
	localparam int CFG_B = 1;
	localparam int CFG_C = 2;
	localparam int CFG_D = 3;
	localparam int CFG_E = 4;
	localparam int CFG_F = 5;
	localparam int CFG_G = 6;
	localparam logic [7:0] CFG_CODE [NCFG] = '{8'h39, 8'h3C, 8'h3D, 8'h4C,
		8'h4E, 8'h38, 8'h37};
	localparam logic [15:0] CFG_MASK [NCFG] = '{16'hFFFF, 16'hFF77,
		16'hEFFD, 16'hFDFF, 16'hFBFD, 16'hFFFF, 16'h00FF};
	localparam logic [15:0] CFG_RESET [NCFG] = '{16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0003};

	// discharge alert threshold layout
	localparam logic [15:0] THR_RESET = 16'h1000;
	localparam int THR_LSB = 8;
	localparam int THR_MSB = 13;
	localparam logic [5:0] THR_MAX = 6'h32;
	localparam logic [15:0] LP_THR_MA [4] = '{16'd12000, 16'd10000,
		16'd8000, 16'd6000};

	// field positions
	localparam int A_TIMEOUT_DIS = 7;
	localparam int A_LP_THR = 3;
	localparam int B_CMP_DB = 14;
	localparam int B_LEARN_EXIT = 13;
	localparam int B_LEARN = 12;
	localparam int B_REV = 11;
	localparam int B_FREQ = 8;
	localparam int B_TURBO_DIS = 6;
	localparam int B_MON_DIS = 5;
	localparam int B_MON_SEL = 4;
	localparam int B_SYS_DIS = 2;
	localparam int B_LOW_RAIL = 0;
	localparam int C_TRICKLE = 14;
	localparam int C_REV_DLY = 13;
	localparam int C_ADP_DB = 11;
	localparam int C_ALERT_DB = 9;
	localparam int C_ALERT_DUR = 6;
	localparam int D_REV_DLY = 0;
	localparam int E_ALERT_CLR = 1;
	localparam int E_ALERT_LATCH = 0;

	// times in microseconds, TIMEOUT_S in seconds
	localparam cnt_t ALERT_DB_US [4] = '{28'd7, 28'd100, 28'd500, 28'd1000};
	localparam cnt_t LOW_RAIL_DB_US = 28'd8;
	localparam cnt_t ALERT_DUR_US [8] = '{28'd10000, 28'd20000, 28'd15000,
		28'd5000, 28'd1000, 28'd500, 28'd100, 28'd0};
	localparam cnt_t REV_DLY_US [4] = '{28'd1300000, 28'd1550000,
		28'd150000, 28'd7500};
	localparam cnt_t ADP_DB_US [2] = '{28'd1300000, 28'd150000};
	localparam int TIMEOUT_S = 175;
	localparam int TIMEOUT_US = TIMEOUT_S * US_PER_S;

	typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_CMD, PH_DLO, PH_DHI,
		PH_RLO, PH_RHI, PH_SKIP} phase_t;
endpackage

// >>> core/charger_alert_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module charger_alert_config_regs
	import charger_alert_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
	parameter int US_CYC = CYC_PER_US,
	parameter int TIMEOUT_TICKS = TIMEOUT_US
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic [15:0] discharge_current_ma,
	input wire logic adapter_overcurrent_level,
	input wire logic low_rail_trip,
	input wire logic low_power_mode,
	input wire logic adapter_present,
	input wire logic battery_absent,
	input wire logic battery_below_min,
	input wire logic turbo_active,
	input wire logic limit_write,
	output logic alert_n,
	output logic [1:0] low_rail_threshold_sel,
	output logic [1:0] comparator_db_sel,
	output logic learn_mode,
	output logic reverse_power_mode,
	output logic input_switch_gate,
	output logic [1:0] trickle_current_sel,
	output logic [1:0] switching_freq_sel,
	output logic monitor_enable,
	output logic monitor_select,
	output logic switching_enable,
	output logic battery_switch_gate,
	output logic charge_enable
);
	localparam logic [7:0] US_CYC_M1 = 8'(US_CYC - 1);
	localparam cnt_t TIMEOUT_CNT = cnt_t'(TIMEOUT_TICKS);
	// idle levels: bus lines high, status pins low
	localparam logic [5:0] SYNC_IDLE = 6'h03;

	// input synchronisers: scl, sda, adapter, battery, overcurrent, rail
	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= SYNC_IDLE;
			sync2_r <= SYNC_IDLE;
		end else begin
			sync1_r <= {low_rail_trip, adapter_overcurrent_level,
				battery_absent, adapter_present, sda_in, scl_in};
			sync2_r <= sync1_r;
		end
	end
	wire scl_s = sync2_r[0];
	wire sda_s = sync2_r[1];
	wire adp_s = sync2_r[2];
	wire bat_abs_s = sync2_r[3];
	wire acov_s = sync2_r[4];
	wire lowrail_s = sync2_r[5];

	// microsecond tick
	logic [7:0] us_cnt_r;
	logic tick_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			us_cnt_r <= 8'h00;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (us_cnt_r == US_CYC_M1);
			us_cnt_r <= (us_cnt_r == US_CYC_M1) ? 8'h00 : us_cnt_r + 8'h01;
		end
	end

	// serial bus slave
	phase_t phase_r;
	phase_t phase_nxt;
	logic scl_d_r;
	logic sda_d_r;
	logic [3:0] bit_cnt_r;
	logic ack_r;
	logic [7:0] shift_r;
	logic [7:0] cmd_r;
	logic [7:0] lo_r;
	logic [7:0] tx_r;
	logic oe_n_r;
	logic oe_n_nxt;
	logic [15:0] rd_word;

	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;
	wire bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;
	wire bit_in = scl_rise & ~ack_r & (bit_cnt_r != 4'd8);
	wire byte_end = scl_fall & ~ack_r & (bit_cnt_r == 4'd8);
	wire ack_end = scl_fall & ack_r;
	wire rd_ph = (phase_r == PH_RLO) | (phase_r == PH_RHI);
	wire host_ack = scl_rise & ack_r & rd_ph & oe_n_r;
	wire next_bit = scl_fall & ~ack_r & rd_ph & (bit_cnt_r != 4'd0)
		& (bit_cnt_r != 4'd8);
	wire addr_ok = (shift_r[7:1] == DEV_ADDR);
	wire cmd_is_g = (cmd_r == CFG_CODE[CFG_G]);
	wire wr_ack = ((phase_r == PH_ADDR) & addr_ok) | (phase_r == PH_CMD)
		| (phase_r == PH_DLO) | (phase_r == PH_DHI);
	wire wr_pulse = byte_end & ((phase_r == PH_DHI)
		| ((phase_r == PH_DLO) & cmd_is_g));
	wire [15:0] wr_data = (phase_r == PH_DHI) ? {shift_r, lo_r}
		: {8'h00, shift_r};

	always_comb begin
		phase_nxt = phase_r;
		if (bus_start) begin
			phase_nxt = PH_ADDR;
		end else if (bus_stop) begin
			phase_nxt = PH_IDLE;
		end else if (byte_end) begin
			unique case (phase_r)
				PH_ADDR: phase_nxt = !addr_ok ? PH_SKIP
					: (shift_r[0] ? PH_RLO : PH_CMD);
				PH_CMD: phase_nxt = PH_DLO;
				PH_DLO: phase_nxt = cmd_is_g ? PH_SKIP : PH_DHI;
				PH_DHI: phase_nxt = PH_SKIP;
				PH_IDLE, PH_RLO, PH_RHI, PH_SKIP: phase_nxt = phase_r;
			endcase
		end else if (host_ack) begin
			phase_nxt = (sda_s || phase_r == PH_RHI) ? PH_SKIP : PH_RHI;
		end
	end

	always_comb begin
		oe_n_nxt = oe_n_r;
		if (bus_start || bus_stop) begin
			oe_n_nxt = 1'b1;
		end else if (byte_end) begin
			oe_n_nxt = ~wr_ack;
		end else if ((ack_end || next_bit) && rd_ph) begin
			oe_n_nxt = tx_r[7];
		end else if (ack_end) begin
			oe_n_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= PH_IDLE;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			oe_n_r <= 1'b1;
		end else begin
			phase_r <= phase_nxt;
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			oe_n_r <= oe_n_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_r <= 4'd0;
			ack_r <= 1'b0;
			shift_r <= 8'h00;
		end else if (bus_start) begin
			bit_cnt_r <= 4'd0;
			ack_r <= 1'b0;
		end else begin
			if (bit_in) begin
				shift_r <= {shift_r[6:0], sda_s};
				bit_cnt_r <= bit_cnt_r + 4'd1;
			end
			if (byte_end) begin
				ack_r <= 1'b1;
				bit_cnt_r <= 4'd0;
			end
			if (ack_end) begin
				ack_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_r <= 8'h00;
			lo_r <= 8'h00;
			tx_r <= 8'h00;
		end else begin
			if (byte_end && phase_r == PH_CMD) begin
				cmd_r <= shift_r;
			end
			if (byte_end && phase_r == PH_DLO) begin
				lo_r <= shift_r;
			end
			if (byte_end && phase_r == PH_ADDR) begin
				tx_r <= rd_word[7:0];
			end else if (host_ack && phase_r == PH_RLO) begin
				tx_r <= rd_word[15:8];
			end else if ((ack_end || next_bit) && rd_ph) begin
				tx_r <= {tx_r[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end
	assign sda_oe_n = oe_n_r;

	// discharge alert threshold
	logic [5:0] thr_r;
	wire thr_hit = wr_pulse & (cmd_r == CMD_THR);
	wire [5:0] thr_in = wr_data[THR_MSB:THR_LSB];
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			thr_r <= THR_RESET[THR_MSB:THR_LSB];
		end else if (thr_hit) begin
			thr_r <= (thr_in > THR_MAX) ? THR_MAX : thr_in;
		end
	end
	wire [15:0] thr_word = {2'b00, thr_r, 8'h00};

	// configuration words
	logic [15:0] cfg_r [NCFG];
	genvar gi;
	generate
		for (gi = 0; gi < NCFG; gi++) begin : g_cfg
			wire hit = wr_pulse & (cmd_r == CFG_CODE[gi]);
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					cfg_r[gi] <= CFG_RESET[gi];
				end else if (hit) begin
					cfg_r[gi] <= wr_data & CFG_MASK[gi];
				end
			end
		end
	endgenerate
	wire alert_clr = wr_pulse & (cmd_r == CFG_CODE[CFG_E])
		& wr_data[E_ALERT_CLR];

	always_comb begin
		rd_word = 16'h0000;
		if (cmd_r == CMD_THR) begin
			rd_word = thr_word;
		end
		for (int i = 0; i < NCFG; i++) begin
			if (cmd_r == CFG_CODE[i]) begin
				rd_word = cfg_r[i];
			end
		end
	end

	// alert path
	wire [1:0] lp_sel = cfg_r[CFG_A][A_LP_THR +: 2];
	wire [1:0] db_sel = cfg_r[CFG_C][C_ALERT_DB +: 2];
	wire [2:0] dur_sel = cfg_r[CFG_C][C_ALERT_DUR +: 3];
	wire [15:0] act_thr = low_power_mode ? LP_THR_MA[lp_sel]
		: thr_word;
	wire over = (discharge_current_ma > act_thr) | acov_s;
	logic alert_r;
	logic alert_nxt;
	cnt_t db_cnt_r;
	cnt_t lr_cnt_r;
	cnt_t hold_r;
	wire db_done = db_cnt_r >= ALERT_DB_US[db_sel];
	wire lr_done = lr_cnt_r >= LOW_RAIL_DB_US;
	wire trip = (over & db_done) | (lowrail_s & lr_done);
	wire latch = cfg_r[CFG_E][E_ALERT_LATCH];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			db_cnt_r <= '0;
			lr_cnt_r <= '0;
		end else begin
			if (!over) begin
				db_cnt_r <= '0;
			end else if (tick_r && !db_done) begin
				db_cnt_r <= db_cnt_r + 1'b1;
			end
			if (!lowrail_s) begin
				lr_cnt_r <= '0;
			end else if (tick_r && !lr_done) begin
				lr_cnt_r <= lr_cnt_r + 1'b1;
			end
		end
	end

	always_comb begin
		alert_nxt = alert_r;
		if (trip) begin
			alert_nxt = 1'b1;
		end else if (alert_clr) begin
			alert_nxt = 1'b0;
		end else if (!latch && hold_r == '0) begin
			alert_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			alert_r <= 1'b0;
			alert_n <= 1'b1;
			hold_r <= '0;
		end else begin
			alert_r <= alert_nxt;
			alert_n <= ~alert_nxt;
			if (trip && !alert_r) begin
				hold_r <= ALERT_DUR_US[dur_sel];
			end else if (tick_r && hold_r != '0) begin
				hold_r <= hold_r - 1'b1;
			end
		end
	end

	// host activity timeout
	cnt_t to_cnt_r;
	logic stop_r;
	wire to_run = ~cfg_r[CFG_A][A_TIMEOUT_DIS] & adp_s;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			to_cnt_r <= '0;
			stop_r <= 1'b0;
			charge_enable <= 1'b1;
		end else begin
			if (limit_write || !to_run) begin
				to_cnt_r <= '0;
				stop_r <= 1'b0;
			end else if (to_cnt_r >= TIMEOUT_CNT) begin
				stop_r <= 1'b1;
			end else if (tick_r) begin
				to_cnt_r <= to_cnt_r + 1'b1;
			end
			charge_enable <= ~stop_r;
		end
	end

	// learn mode
	logic learn_exit_r;
	wire [15:0] wb = cfg_r[CFG_B];
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			learn_exit_r <= 1'b0;
			learn_mode <= 1'b0;
		end else begin
			if (!wb[B_LEARN]) begin
				learn_exit_r <= 1'b0;
			end else if (learn_mode && wb[B_LEARN_EXIT]
				&& battery_below_min) begin
				learn_exit_r <= 1'b1;
			end
			learn_mode <= wb[B_LEARN] & ~bat_abs_s & ~learn_exit_r;
		end
	end

	// reverse mode start-up
	cnt_t rev_cnt_r;
	wire [1:0] rev_sel = {cfg_r[CFG_C][C_REV_DLY], cfg_r[CFG_D][D_REV_DLY]};
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rev_cnt_r <= '0;
			reverse_power_mode <= 1'b0;
		end else if (!wb[B_REV]) begin
			rev_cnt_r <= '0;
			reverse_power_mode <= 1'b0;
		end else if (rev_cnt_r >= REV_DLY_US[rev_sel]) begin
			reverse_power_mode <= 1'b1;
		end else if (tick_r) begin
			rev_cnt_r <= rev_cnt_r + 1'b1;
		end
	end

	// adapter insertion debounce
	cnt_t adp_cnt_r;
	logic adp_off_seen_r;
	wire adp_sel = ~adp_off_seen_r | cfg_r[CFG_C][C_ADP_DB];
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			adp_cnt_r <= '0;
			adp_off_seen_r <= 1'b0;
			input_switch_gate <= 1'b0;
		end else if (!adp_s) begin
			adp_cnt_r <= '0;
			input_switch_gate <= 1'b0;
			if (input_switch_gate) begin
				adp_off_seen_r <= 1'b1;
			end
		end else if (adp_cnt_r >= ADP_DB_US[adp_sel]) begin
			input_switch_gate <= 1'b1;
		end else if (tick_r) begin
			adp_cnt_r <= adp_cnt_r + 1'b1;
		end
	end

	// derived controls
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			monitor_enable <= 1'b1;
			switching_enable <= 1'b1;
			battery_switch_gate <= 1'b0;
		end else begin
			monitor_enable <= adp_s | ~wb[B_MON_DIS];
			switching_enable <= ~wb[B_SYS_DIS];
			battery_switch_gate <= wb[B_SYS_DIS]
				| (turbo_active & ~wb[B_TURBO_DIS]);
		end
	end

	assign monitor_select = wb[B_MON_SEL];
	assign low_rail_threshold_sel = wb[B_LOW_RAIL +: 2];
	assign comparator_db_sel = wb[B_CMP_DB +: 2];
	assign switching_freq_sel = wb[B_FREQ +: 2];
	assign trickle_current_sel = cfg_r[CFG_C][C_TRICKLE +: 2];
endmodule // charger_alert_config_regs
`default_nettype wire

// >>> verification/smbus_host.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_host
	import charger_alert_pkg::*;
(
	input wire logic clk,
	input wire logic sda_w,
	output var logic scl,
	output var logic sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic h();
		repeat (8) @(posedge clk);
	endtask
	task automatic bt(input logic b, output logic r);
		repeat (4) @(posedge clk);
		sda <= b;
		h();
		scl <= 1'b1;
		h();
		r = sda_w;
		scl <= 1'b0;
	endtask
	task automatic xb(input logic [7:0] d, input logic l,
		output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bt(d[i], q[i]);
		end
		bt(l, a);
	endtask
	task automatic st();
		h();
		sda <= 1'b1;
		h();
		scl <= 1'b1;
		h();
		sda <= 1'b0;
		h();
		scl <= 1'b0;
	endtask
	task automatic sp();
		h();
		sda <= 1'b0;
		h();
		scl <= 1'b1;
		h();
		sda <= 1'b1;
		h();
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d,
		input int n);
		logic [7:0] q;
		st();
		xb({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, q);
		xb(c, 1'b1, q);
		xb(d[7:0], 1'b1, q);
		if (n > 1) begin
			xb(d[15:8], 1'b1, q);
		end
		sp();
	endtask
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		st();
		xb({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, d[7:0]);
		xb(c, 1'b1, d[7:0]);
		st();
		xb({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, d[7:0]);
		xb(8'hFF, 1'b0, d[7:0]);
		xb(8'hFF, 1'b1, d[15:8]);
		sp();
	endtask
endmodule // smbus_host
`default_nettype wire

// >>> verification/charger_alert_config_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module alert_chk #(
	parameter int US_CYC = 40,
	parameter int TIMEOUT_TICKS = 50
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [15:0] discharge_current_ma,
	input wire logic adapter_overcurrent_level,
	input wire logic low_rail_trip,
	input wire logic adapter_present,
	input wire logic battery_absent,
	input wire logic turbo_active,
	input wire logic limit_write,
	input wire logic alert_n,
	input wire logic learn_mode,
	input wire logic reverse_power_mode,
	input wire logic monitor_enable,
	input wire logic switching_enable,
	input wire logic battery_switch_gate,
	input wire logic charge_enable
);
	localparam int TO_MIN = (TIMEOUT_TICKS - 1) * US_CYC;
	logic cause;
	logic [31:0] idle_r;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	assign cause = low_rail_trip | adapter_overcurrent_level |
		(discharge_current_ma != 16'h0000);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_r <= '0;
		end else if (limit_write || !adapter_present) begin
			idle_r <= '0;
		end else begin
			idle_r <= idle_r + 32'h1;
		end
	end
	alert_cause_a: assert property (
		$fell(alert_n) |-> $past(cause, 2) && $past(cause, 5))
		else $error("alert fell without cause");
	low_rail_a: assert property (
		$rose(low_rail_trip) ##1 low_rail_trip[*8] ##1
		low_rail_trip[*6] |=> !alert_n)
		else $error("low rail alert late");
	timeout_wait_a: assert property (
		$fell(charge_enable) |-> idle_r >= TO_MIN)
		else $error("charging stopped early");
	charge_resume_a: assert property (
		limit_write |-> ##[1:4] charge_enable)
		else $error("charging not resumed");
	mon_force_a: assert property (
		adapter_present[*4] |-> monitor_enable)
		else $error("monitor off with adapter");
	sys_off_a: assert property (
		!switching_enable |-> battery_switch_gate)
		else $error("gate off while output disabled");
	turbo_gate_a: assert property (
		$rose(battery_switch_gate) && switching_enable |->
		$past(turbo_active))
		else $error("gate on without turbo");
	learn_block_a: assert property (
		battery_absent[*5] |-> !learn_mode)
		else $error("learn mode without battery");
	cover property ($fell(alert_n));
	cover property ($fell(charge_enable));
	cover property ($rose(reverse_power_mode));
endmodule // alert_chk
bind charger_alert_config_regs alert_chk #(
	.US_CYC(US_CYC),
	.TIMEOUT_TICKS(TIMEOUT_TICKS)
) alert_chk_inst (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.discharge_current_ma(discharge_current_ma),
	.adapter_overcurrent_level(adapter_overcurrent_level),
	.low_rail_trip(low_rail_trip),
	.adapter_present(adapter_present),
	.battery_absent(battery_absent),
	.turbo_active(turbo_active),
	.limit_write(limit_write),
	.alert_n(alert_n),
	.learn_mode(learn_mode),
	.reverse_power_mode(reverse_power_mode),
	.monitor_enable(monitor_enable),
	.switching_enable(switching_enable),
	.battery_switch_gate(battery_switch_gate),
	.charge_enable(charge_enable)
);
`default_nettype wire

// >>> verification/charger_alert_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module charger_alert_config_regs_tb;
	import charger_alert_pkg::*;
	localparam int TO = 50;
	logic ref_clk, rst_n, scl_in, sda_in, sda_h, sda_out, sda_oe_n;
	logic adapter_overcurrent_level, low_rail_trip, low_power_mode;
	logic adapter_present, battery_absent, battery_below_min;
	logic turbo_active, limit_write, alert_n, learn_mode;
	logic reverse_power_mode, input_switch_gate, monitor_enable;
	logic monitor_select, switching_enable, battery_switch_gate;
	logic charge_enable;
	logic [15:0] discharge_current_ma;
	logic [1:0] low_rail_threshold_sel, comparator_db_sel;
	logic [1:0] trickle_current_sel, switching_freq_sel;
	int n_mismatch = 0;
	int checks_done = 0;
	int cyc = 0;
	assign sda_in = sda_h & (sda_oe_n | sda_out);
	charger_alert_config_regs #(
		.US_CYC(1),
		.TIMEOUT_TICKS(TO)
	) charger_alert_config_regs_inst (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.discharge_current_ma(discharge_current_ma),
		.adapter_overcurrent_level(adapter_overcurrent_level),
		.low_rail_trip(low_rail_trip),
		.low_power_mode(low_power_mode),
		.adapter_present(adapter_present),
		.battery_absent(battery_absent),
		.battery_below_min(battery_below_min),
		.turbo_active(turbo_active),
		.limit_write(limit_write),
		.alert_n(alert_n),
		.low_rail_threshold_sel(low_rail_threshold_sel),
		.comparator_db_sel(comparator_db_sel),
		.learn_mode(learn_mode),
		.reverse_power_mode(reverse_power_mode),
		.input_switch_gate(input_switch_gate),
		.trickle_current_sel(trickle_current_sel),
		.switching_freq_sel(switching_freq_sel),
		.monitor_enable(monitor_enable),
		.monitor_select(monitor_select),
		.switching_enable(switching_enable),
		.battery_switch_gate(battery_switch_gate),
		.charge_enable(charge_enable)
	);
	smbus_host smbus_host_inst (
		.clk(ref_clk),
		.sda_w(sda_in),
		.scl(scl_in),
		.sda(sda_h)
	);
	task automatic stop_test();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wreg(input logic [7:0] c, input logic [15:0] d);
		smbus_host_inst.wr(c, d, c == 8'h37 ? 1 : 2);
	endtask
	task automatic rchk(input logic [7:0] c, input logic [15:0] e);
		logic [15:0] q;
		smbus_host_inst.rd(c, q);
		chk("register", e, q);
	endtask
	task automatic cur(input logic [15:0] ma, input int n);
		discharge_current_ma <= ma;
		cy(n);
	endtask
	task automatic t_regs();
		rchk(CMD_THR, THR_RESET);
		for (int k = 0; k < NCFG; k++) begin
			rchk(CFG_CODE[k], CFG_RESET[k]);
			wreg(CFG_CODE[k], 16'hFFFF);
			rchk(CFG_CODE[k], CFG_MASK[k]);
			wreg(CFG_CODE[k], CFG_RESET[k]);
		end
		rchk(8'h50, 16'h0000);
	endtask
	task automatic t_thr();
		logic [15:0] wv [3] = '{16'hFFFF, 16'h3300, 16'h2A55};
		logic [15:0] ev [3] = '{16'h3200, 16'h3200, 16'h2A00};
		for (int k = 0; k < 3; k++) begin
			wreg(CMD_THR, wv[k]);
			rchk(CMD_THR, ev[k]);
		end
	endtask
	task automatic t_fields();
		logic [1:0] k;
		for (int i = 0; i < 4; i++) begin
			k = 2'(i);
			wreg(CFG_CODE[CFG_B], {k, 4'h0, k, 6'h00, k});
			wreg(CFG_CODE[CFG_C], {k, 14'h0000});
			chk("cmp_db", k, comparator_db_sel);
			chk("freq", k, switching_freq_sel);
			chk("rail_sel", k, low_rail_threshold_sel);
			chk("trickle", k, trickle_current_sel);
		end
	endtask
	task automatic t_alert();
		int n;
		wreg(CMD_THR, 16'h0400);
		for (int d = 0; d < 4; d++) begin
			wreg(CFG_CODE[CFG_C], 16'(d << 9) | 16'h01C0);
			n = int'(ALERT_DB_US[d]);
			cur(16'h0400, n + 20);
			chk("alert", 1, alert_n);
			cur(16'h044C, n - 3);
			chk("alert", 1, alert_n);
			cy(12);
			chk("alert", 0, alert_n);
			cur(0, 8);
			chk("alert", 1, alert_n);
		end
		wreg(CFG_CODE[CFG_C], 16'h0100);
		cur(16'h044C, 20);
		cur(0, 950);
		chk("alert", 0, alert_n);
		cy(100);
		chk("alert", 1, alert_n);
		wreg(CFG_CODE[CFG_E], 16'h0001);
		wreg(CFG_CODE[CFG_C], 16'h01C0);
		cur(16'h044C, 20);
		cur(0, 50);
		chk("alert", 0, alert_n);
		wreg(CFG_CODE[CFG_E], 16'h0003);
		chk("alert", 1, alert_n);
		wreg(CFG_CODE[CFG_E], 16'h0000);
		low_power_mode <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			wreg(CFG_CODE[CFG_A], 16'(k << 3));
			cur(LP_THR_MA[k], 40);
			chk("alert", 1, alert_n);
			cur(LP_THR_MA[k] + 16'h0064, 30);
			chk("alert", 0, alert_n);
			cur(0, 8);
		end
		low_power_mode <= 1'b0;
		wreg(CFG_CODE[CFG_C], 16'h07C0);
		low_rail_trip <= 1'b1;
		cy(9);
		chk("alert", 1, alert_n);
		cy(11);
		chk("alert", 0, alert_n);
		low_rail_trip <= 1'b0;
		cy(8);
		adapter_overcurrent_level <= 1'b1;
		cy(990);
		chk("alert", 1, alert_n);
		cy(20);
		chk("alert", 0, alert_n);
		adapter_overcurrent_level <= 1'b0;
		cy(8);
	endtask
	task automatic t_mon();
		wreg(CFG_CODE[CFG_B], 16'h0030);
		chk("mon_en", 0, monitor_enable);
		chk("mon_sel", 1, monitor_select);
		adapter_present <= 1'b1;
		cy(6);
		chk("mon_en", 1, monitor_enable);
		chk("sw_gate", 0, input_switch_gate);
		limit_write <= 1'b1;
		cy(1);
		limit_write <= 1'b0;
		cy(TO - 10);
		chk("charge", 1, charge_enable);
		cy(20);
		chk("charge", 0, charge_enable);
		limit_write <= 1'b1;
		cy(1);
		limit_write <= 1'b0;
		cy(4);
		chk("charge", 1, charge_enable);
		adapter_present <= 1'b0;
	endtask
	task automatic t_learn();
		battery_absent <= 1'b1;
		wreg(CFG_CODE[CFG_B], 16'h1000);
		cy(6);
		chk("learn", 0, learn_mode);
		battery_absent <= 1'b0;
		cy(6);
		chk("learn", 1, learn_mode);
		wreg(CFG_CODE[CFG_B], 16'h3000);
		battery_below_min <= 1'b1;
		cy(4);
		battery_below_min <= 1'b0;
		cy(4);
		chk("learn", 0, learn_mode);
		wreg(CFG_CODE[CFG_C], 16'h2000);
		wreg(CFG_CODE[CFG_D], 16'h0001);
		wreg(CFG_CODE[CFG_B], 16'h0800);
		cy(7400);
		chk("reverse", 0, reverse_power_mode);
		cy(200);
		chk("reverse", 1, reverse_power_mode);
		turbo_active <= 1'b1;
		wreg(CFG_CODE[CFG_B], 16'h0000);
		chk("reverse", 0, reverse_power_mode);
		chk("gate", 1, battery_switch_gate);
		wreg(CFG_CODE[CFG_B], 16'h0040);
		chk("gate", 0, battery_switch_gate);
		turbo_active <= 1'b0;
		wreg(CFG_CODE[CFG_B], 16'h0004);
		chk("switching", 0, switching_enable);
		chk("gate", 1, battery_switch_gate);
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 100000) begin
			n_mismatch++;
			stop_test();
		end
	end
	initial begin
		rst_n = 1'b0;
		discharge_current_ma = 16'h0000;
		adapter_overcurrent_level = 1'b0;
		low_rail_trip = 1'b0;
		low_power_mode = 1'b0;
		adapter_present = 1'b0;
		battery_absent = 1'b0;
		battery_below_min = 1'b0;
		turbo_active = 1'b0;
		limit_write = 1'b0;
		cy(12);
		rst_n <= 1'b1;
		cy(6);
		t_regs();
		t_thr();
		t_fields();
		t_alert();
		t_mon();
		t_learn();
		stop_test();
	end
endmodule // charger_alert_config_regs_tb
`default_nettype wire
